// ### bwm_pkg.sv
// Package with offsets, field layout, security spaces and request carrier for the feature block
`default_nettype none

package bwm_pkg;

  // Number of security address spaces, one feature frame each
  localparam int BWM_NUM_SPACES = 4;

  // Register offsets inside each feature frame
  localparam logic [11:0] BWM_OFF_MON_FEAT = 12'h080;
  localparam logic [11:0] BWM_OFF_BWU_FEAT = 12'h090;

  // Bandwidth usage monitor feature register layout
  localparam int BWM_BIT_RWBW = 28;
  localparam int BWM_BIT_OFSR = 26;
  localparam int BWM_SCALE_LSB = 16;
  localparam int BWM_SCALE_W = 5;
  localparam int BWM_NUMMON_LSB = 0;
  localparam int BWM_NUMMON_W = 16;

  // General monitoring feature register layout
  localparam int BWM_BIT_LCAP = 31;
  localparam int BWM_BIT_NOWIRED = 30;
  localparam int BWM_BIT_MSGW = 29;
  localparam int BWM_BIT_OFLSR = 28;
  localparam int BWM_BIT_MBWU = 17;

  // Reserved masks: ones where a bit may be nonzero
  localparam logic [31:0] BWM_BWU_USED_MASK = 32'h141FFFFF;
  localparam logic [31:0] BWM_MON_USED_MASK = 32'hF0020000;

  // Reset values of the answer and interrupt flops
  localparam logic [31:0] BWM_RDATA_RST = 32'h00000000;
  localparam logic BWM_FLAG_RST = 1'b0;

  // Security space of an access
  typedef enum logic [1:0] {
    BWM_SECURE,
    BWM_NONSECURE,
    BWM_ROOT,
    BWM_REALM
  } bwm_space_e;

  // One register access from the feature frame decoder
  typedef struct packed {
    logic wr;
    bwm_space_e space;
    logic [11:0] offset;
    logic [31:0] wdata;
  } bwm_acc_s;

endpackage : bwm_pkg

`default_nettype wire

// ### bwm_feature_regs.sv
// Read-only bandwidth and general monitoring feature registers, one copy per security space
`default_nettype none

//Contract
// - Bit 28 reports read/write bandwidth selection; zero without an extended version.
// - Bit 26 reports overflow bitmap register; zero without an extended version.
// - Bits 20:16 give counter right-shift; zero means no scaling.
// - Bits 15:0 give monitor count; software selects at most count minus one.
// - Bandwidth feature register at 0x0090 in every frame; root/realm need realm support.
// - Both registers are read-only; writes never change reported values.
// - Each security space has its own copy, same or different contents.
// - Per-instance fields follow partition select instance; others stay constant.
// - Monitor select instance field has no effect on these reads.
// - General monitoring register reads zero unless monitoring is present.
// - Bit 31 reports the local capture event generator.
// - Bit 30 set means no wired overflow interrupt; needs version 1.1.
// - Bit 29 reports message-write overflow signalling; needs version 1.1.
// - Bit 30 set and bit 29 clear means no overflow interrupts at all.
// - Bit 28 reports overflow status register; needs version 1.1.
// - Bit 17 reports bandwidth usage monitoring and gates its registers.
// - General monitoring register is 32 bits, readable from each frame.
// - General monitoring register at 0x0080 in every frame.
module bwm_feature_regs
  import bwm_pkg::*;
#(
  parameter int NUM_RI = 1,
  parameter int RI_W = 4,
  parameter bit EXT_V01_V11 = 1'b1,
  parameter bit EXT_V11 = 1'b1,
  parameter bit REALM_MGMT = 1'b1,
  parameter bit INST_SUPPORT = 1'b0,
  parameter bit MON_PRESENT = 1'b1,
  parameter bit LOCAL_CAPT = 1'b0,
  parameter bit NO_WIRED = 1'b0,
  parameter bit MSG_WRITE = 1'b1,
  parameter bit OFL_SR = 1'b1,
  parameter logic [BWM_NUM_SPACES*NUM_RI-1:0] MBWU_TBL = '1,
  parameter logic [BWM_NUM_SPACES*NUM_RI-1:0] RWBW_TBL = '1,
  parameter logic [BWM_NUM_SPACES*NUM_RI-1:0] OFSR_TBL = '1,
  parameter logic [BWM_NUM_SPACES*NUM_RI*BWM_SCALE_W-1:0] SCALE_TBL = '0,
  parameter logic [BWM_NUM_SPACES*NUM_RI*BWM_NUMMON_W-1:0] NUMMON_TBL =
    {(BWM_NUM_SPACES*NUM_RI){16'h0004}}
) (
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic acc_valid, // Access strobe, one cycle per access
  input wire bwm_acc_s acc_req, // Access kind, space, offset, write data
  input wire logic [RI_W-1:0] part_sel_instance, // Partition select instance field
  input wire logic ovf_event, // Monitor overflow event pulse
  output logic rsp_valid_reg, // Answer strobe, one cycle after the access
  output logic [31:0] rsp_rdata_reg, // Read data, zero for writes
  output logic wired_irq_reg, // Wired overflow interrupt pulse
  output logic msg_irq_req_reg // Overflow message write request pulse
);

  // Bandwidth monitor feature word for one space and instance
  function automatic logic [31:0] bwu_word(input int idx);
    logic [31:0] w;
    w = '0;
    w[BWM_BIT_RWBW] = EXT_V01_V11 & RWBW_TBL[idx];
    w[BWM_BIT_OFSR] = EXT_V01_V11 & OFSR_TBL[idx];
    w[BWM_SCALE_LSB +: BWM_SCALE_W] = SCALE_TBL[idx*BWM_SCALE_W +: BWM_SCALE_W];
    w[BWM_NUMMON_LSB +: BWM_NUMMON_W] = NUMMON_TBL[idx*BWM_NUMMON_W +: BWM_NUMMON_W];
    return w;
  endfunction

  // General monitoring feature word; only bit 17 varies by instance
  function automatic logic [31:0] mon_word(input int idx);
    logic [31:0] w;
    w = '0;
    w[BWM_BIT_LCAP] = LOCAL_CAPT;
    w[BWM_BIT_NOWIRED] = EXT_V11 & NO_WIRED;
    w[BWM_BIT_MSGW] = EXT_V11 & MSG_WRITE;
    w[BWM_BIT_OFLSR] = EXT_V11 & OFL_SR;
    w[BWM_BIT_MBWU] = MBWU_TBL[idx];
    return w;
  endfunction

  // Instance steering: only the partition select field is consulted
  logic [RI_W-1:0] inst_eff;
  logic inst_ok;
  logic space_ok;
  int tbl_idx;
  assign inst_eff = INST_SUPPORT ? part_sel_instance : '0;
  assign inst_ok = (int'(inst_eff) < NUM_RI);
  assign space_ok = (acc_req.space == BWM_SECURE) || (acc_req.space == BWM_NONSECURE) ||
                    REALM_MGMT;
  assign tbl_idx = inst_ok ? (int'(acc_req.space) * NUM_RI + int'(inst_eff)) : 0;

  // Register contents for the addressed space and instance
  logic [31:0] mon_val;
  logic [31:0] bwu_val;
  logic [31:0] rd_sel;
  logic rd_req;
  assign mon_val = (MON_PRESENT && inst_ok) ? mon_word(tbl_idx) : '0;
  assign bwu_val = mon_val[BWM_BIT_MBWU] ? bwu_word(tbl_idx) : '0;
  assign rd_req = acc_valid && !acc_req.wr && space_ok;
  assign rd_sel = !rd_req ? '0 :
                  (acc_req.offset == BWM_OFF_MON_FEAT) ? mon_val :
                  (acc_req.offset == BWM_OFF_BWU_FEAT) ? bwu_val : '0;

  // Overflow signalling paths allowed by the reported features
  logic wired_ok;
  logic msg_ok;
  assign wired_ok = !(EXT_V11 && NO_WIRED);
  assign msg_ok = EXT_V11 && MSG_WRITE;

  // Answer flops; writes are acknowledged and discarded
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp_valid_reg <= BWM_FLAG_RST;
      rsp_rdata_reg <= BWM_RDATA_RST;
    end else begin
      rsp_valid_reg <= acc_valid;
      rsp_rdata_reg <= rd_sel;
    end
  end

  // Overflow interrupt pulses; both silent when neither path exists
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wired_irq_reg <= BWM_FLAG_RST;
      msg_irq_req_reg <= BWM_FLAG_RST;
    end else begin
      wired_irq_reg <= ovf_event && wired_ok;
      msg_irq_req_reg <= ovf_event && msg_ok;
    end
  end

  // Checks on the answers and interrupt paths
  sequence s_read_bwu;
    acc_valid && !acc_req.wr && acc_req.offset == BWM_OFF_BWU_FEAT && space_ok;
  endsequence

  sequence s_read_mon;
    acc_valid && !acc_req.wr && acc_req.offset == BWM_OFF_MON_FEAT && space_ok;
  endsequence

  sequence s_write_any;
    acc_valid && acc_req.wr;
  endsequence

  answer_latency_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_valid |=> rsp_valid_reg)
    else $error("access not answered next cycle");

  write_no_effect_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_write_any |=> rsp_valid_reg && rsp_rdata_reg == 32'h00000000)
    else $error("write returned data");

  bwu_reserved_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu |=> (rsp_rdata_reg & ~BWM_BWU_USED_MASK) == 32'h00000000)
    else $error("reserved bandwidth bits nonzero");

  mon_reserved_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon |=> (rsp_rdata_reg & ~BWM_MON_USED_MASK) == 32'h00000000)
    else $error("reserved monitoring bits nonzero");

  mon_absent_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon ##0 (!MON_PRESENT) |=> rsp_rdata_reg == 32'h00000000)
    else $error("monitoring register not zero when absent");

  bwu_gated_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu ##0 !mon_val[BWM_BIT_MBWU] |=> rsp_rdata_reg == 32'h00000000)
    else $error("bandwidth register visible without monitoring");

  ext_bits_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu ##0 (!EXT_V01_V11) |=> !rsp_rdata_reg[BWM_BIT_RWBW] && !rsp_rdata_reg[BWM_BIT_OFSR])
    else $error("extended bits set without extension");

  realm_frame_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_valid && !REALM_MGMT && (acc_req.space == BWM_ROOT || acc_req.space == BWM_REALM)
    |=> rsp_rdata_reg == 32'h00000000)
    else $error("root or realm frame answered without realm support");

  irq_silence_a: assert property (@(posedge sys_clk) disable iff (srst)
    ovf_event && EXT_V11 && NO_WIRED && !MSG_WRITE |=> !wired_irq_reg && !msg_irq_req_reg)
    else $error("overflow interrupt signalled with no path");

  wired_irq_path_a: assert property (@(posedge sys_clk) disable iff (srst)
    ovf_event && wired_ok |=> wired_irq_reg ##1 !wired_irq_reg || $past(ovf_event))
    else $error("wired interrupt not raised for overflow");

  const_field_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon ##1 s_read_mon ##0 $stable(acc_req.space) |=>
    rsp_rdata_reg[31:28] == $past(rsp_rdata_reg[31:28]))
    else $error("constant field changed between instances");

  // Read kinds used by the field checks below
  sequence s_read_other;
    acc_valid && !acc_req.wr && acc_req.offset != BWM_OFF_MON_FEAT &&
    acc_req.offset != BWM_OFF_BWU_FEAT;
  endsequence

  sequence s_read_bwu_live;
    s_read_bwu ##0 mon_val[BWM_BIT_MBWU];
  endsequence

  sequence s_read_mon_live;
    s_read_mon ##0 (MON_PRESENT && inst_ok);
  endsequence

  sequence s_quiet;
    !acc_valid;
  endsequence

  // Bandwidth monitor fields follow the table of the addressed space
  bwu_rwbw_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu_live |=>
    rsp_rdata_reg[BWM_BIT_RWBW] == (EXT_V01_V11 && RWBW_TBL[$past(tbl_idx)]))
    else $error("read/write selection bit wrong");

  bwu_ofsr_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu_live |=>
    rsp_rdata_reg[BWM_BIT_OFSR] == (EXT_V01_V11 && OFSR_TBL[$past(tbl_idx)]))
    else $error("overflow bitmap bit wrong");

  bwu_scale_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu_live |=> rsp_rdata_reg[BWM_SCALE_LSB +: BWM_SCALE_W] ==
    SCALE_TBL[$past(tbl_idx)*BWM_SCALE_W +: BWM_SCALE_W])
    else $error("scale field wrong");

  bwu_count_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu_live |=> rsp_rdata_reg[BWM_NUMMON_LSB +: BWM_NUMMON_W] ==
    NUMMON_TBL[$past(tbl_idx)*BWM_NUMMON_W +: BWM_NUMMON_W])
    else $error("monitor count wrong");

  // General monitoring fields: constant capability bits and the per-space bit 17
  mon_lcap_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon_live |=> rsp_rdata_reg[BWM_BIT_LCAP] == LOCAL_CAPT)
    else $error("capture generator bit wrong");

  mon_nowired_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon_live |=> rsp_rdata_reg[BWM_BIT_NOWIRED] == (EXT_V11 && NO_WIRED))
    else $error("no wired interrupt bit wrong");

  mon_msgw_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon_live |=> rsp_rdata_reg[BWM_BIT_MSGW] == (EXT_V11 && MSG_WRITE))
    else $error("message write bit wrong");

  mon_oflsr_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon_live |=> rsp_rdata_reg[BWM_BIT_OFLSR] == (EXT_V11 && OFL_SR))
    else $error("overflow status bit wrong");

  mon_mbwu_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_mon_live |=> rsp_rdata_reg[BWM_BIT_MBWU] == MBWU_TBL[$past(tbl_idx)])
    else $error("bandwidth monitoring bit wrong");

  // Offsets outside the two registers and idle cycles read zero
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_other |=> rsp_rdata_reg == 32'h00000000)
    else $error("unmapped offset returned data");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_quiet |=> !rsp_valid_reg && rsp_rdata_reg == 32'h00000000)
    else $error("answer without access");

  inst_range_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_valid && !inst_ok |=> rsp_rdata_reg == 32'h00000000)
    else $error("out of range instance returned data");

  // Same space and instance give the same word, whatever else changes
  reread_same_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_read_bwu ##1 s_read_bwu ##0 ($stable(acc_req.space) && $stable(inst_eff)) |=>
    rsp_rdata_reg == $past(rsp_rdata_reg))
    else $error("reread of bandwidth register changed");

  // Overflow paths: pulses only for events and only on allowed paths
  msg_irq_path_a: assert property (@(posedge sys_clk) disable iff (srst)
    ovf_event && msg_ok |=> msg_irq_req_reg)
    else $error("message overflow request missing");

  no_event_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    !ovf_event |=> !wired_irq_reg && !msg_irq_req_reg)
    else $error("overflow signalled without event");

  no_msg_path_a: assert property (@(posedge sys_clk) disable iff (srst)
    !msg_ok |=> !msg_irq_req_reg)
    else $error("message request without message path");

  // Reset leaves every output low
  reset_quiet_a: assert property (@(posedge sys_clk)
    srst |=> !rsp_valid_reg && rsp_rdata_reg == 32'h00000000 &&
    !wired_irq_reg && !msg_irq_req_reg)
    else $error("outputs not cleared by reset");

  // Per-space copies: instance zero of each frame shows its own bit 17 and monitor count
  for (genvar sp = 0; sp < BWM_NUM_SPACES; sp++) begin : g_space
    space_mbwu_a: assert property (@(posedge sys_clk) disable iff (srst)
      s_read_mon_live ##0 (acc_req.space == bwm_space_e'(2'(sp)) && inst_eff == '0) |=>
      rsp_rdata_reg[BWM_BIT_MBWU] == MBWU_TBL[sp*NUM_RI])
      else $error("space copy shows wrong contents");

    space_count_a: assert property (@(posedge sys_clk) disable iff (srst)
      s_read_bwu_live ##0 (acc_req.space == bwm_space_e'(2'(sp)) && inst_eff == '0) |=>
      rsp_rdata_reg[BWM_NUMMON_LSB +: BWM_NUMMON_W] ==
      NUMMON_TBL[sp*NUM_RI*BWM_NUMMON_W +: BWM_NUMMON_W])
      else $error("space copy shows wrong count");
  end

endmodule : bwm_feature_regs

`default_nettype wire

// ### bwm_feature_regs_tb_top.sv
// Self-checking bench for the monitoring feature registers
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch %0t %s", $time, m); end end

module bwm_feature_regs_tb_top;
  import bwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Per-space feature tables, LSB entry is the secure frame
  localparam logic [3:0] MB = 4'b1011;
  localparam logic [3:0] RW = 4'b0110;
  localparam logic [3:0] OF = 4'b1010;
  localparam logic [19:0] SC = {5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [63:0] NM = {16'h0008, 16'h0006, 16'h0002, 16'h0004};
  logic sys_clk, srst, acc_valid, ovf_event, ovf_d;
  bwm_acc_s acc_req;
  logic [3:0] part_sel_instance;
  logic rsp_valid_reg, wired_irq_reg, msg_irq_req_reg;
  logic [31:0] rsp_rdata_reg, got_exp;
  logic [31:0] exp_q[$];
  int err_total, total_checks;

  bwm_feature_regs #(.LOCAL_CAPT(1'b1), .MBWU_TBL(MB), .RWBW_TBL(RW), .OFSR_TBL(OF),
    .SCALE_TBL(SC), .NUMMON_TBL(NM)) bwm_feature_regs_inst (
    .sys_clk(sys_clk), .srst(srst), .acc_valid(acc_valid), .acc_req(acc_req),
    .part_sel_instance(part_sel_instance), .ovf_event(ovf_event),
    .rsp_valid_reg(rsp_valid_reg), .rsp_rdata_reg(rsp_rdata_reg),
    .wired_irq_reg(wired_irq_reg), .msg_irq_req_reg(msg_irq_req_reg));

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Expected word of one register in one frame
  function automatic logic [31:0] exp_word(input logic [11:0] o, input int s);
    logic [31:0] w;
    w = 32'h00000000;
    if (o == 12'h080) begin
      w = 32'hB0000000;
      w[17] = MB[s];
    end else if (o == 12'h090 && MB[s]) begin
      w[28] = RW[s];
      w[26] = OF[s];
      w[20:16] = SC[s*5 +: 5];
      w[15:0] = NM[s*16 +: 16];
    end
    return w;
  endfunction

  // One access per cycle; the expected answer goes into the queue
  task automatic acc(input logic w, input int s, input logic [11:0] o, input logic [31:0] e);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_req <= '{wr: w, space: bwm_space_e'(2'(s)), offset: o, wdata: 32'($urandom)};
    part_sel_instance <= 4'($urandom);
    exp_q.push_back(e);
  endtask

  task automatic close_out();
    `CHK(exp_q.size(), 0, "answers missing")
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Output watcher: answers, idle data and overflow signalling
  always @(posedge sys_clk) begin
    ovf_d <= ovf_event;
    if (!srst) begin
      if (rsp_valid_reg === 1'b1) begin
        got_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEADBEEF;
        `CHK(rsp_rdata_reg, got_exp, "read data")
        `CHK(rsp_rdata_reg[28], got_exp[28], "bit 28")
        `CHK(rsp_rdata_reg[26], got_exp[26], "bit 26")
        `CHK(rsp_rdata_reg[20:16], got_exp[20:16], "scale")
        `CHK(rsp_rdata_reg[15:0], got_exp[15:0], "count")
        `CHK(rsp_rdata_reg[31:29], got_exp[31:29], "overflow caps")
        `CHK(rsp_rdata_reg[17], got_exp[17], "bandwidth present")
      end else begin
        `CHK(rsp_rdata_reg, 32'h00000000, "idle data")
      end
      `CHK(wired_irq_reg, ovf_d, "wired overflow")
      `CHK(msg_irq_req_reg, ovf_d, "message overflow")
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    close_out();
  end

  // Main sequence: reads, writes, rereads, unmapped offsets, overflow events
  initial begin
    logic [11:0] o;
    acc_valid = 1'b0;
    acc_req = '0;
    part_sel_instance = 4'h0;
    ovf_event = 1'b0;
    ovf_d = 1'b0;
    srst = 1'b1;
    void'($urandom(32'h2757822d));
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 4; s++) begin
        acc(p == 1, s, 12'h090, (p == 1) ? 32'h00000000 : exp_word(12'h090, s));
        acc(p == 1, s, 12'h080, (p == 1) ? 32'h00000000 : exp_word(12'h080, s));
      end
    end
    for (int i = 0; i < 8; i++) begin
      o = 12'($urandom);
      if (o == 12'h080 || o == 12'h090) o = o ^ 12'h001;
      acc(1'b0, i % 4, o, 32'h00000000);
    end
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      ovf_event <= 1'($urandom);
    end
    @(posedge sys_clk);
    ovf_event <= 1'b0;
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule // bwm_feature_regs_tb_top

`undef CHK
`default_nettype wire
